// *** core/sync_serial_port.v ***
// Synchronous serial port: status, control one, baud generator and shift engines
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"
module sync_serial_port (
  input wire CLK,
  input wire RESETN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire TIMER_MATCH,
  input wire SCK_IN,
  output wire SCK_OUT,
  output wire SCK_OEN,
  input wire SDI,
  output wire SDO,
  output wire SDO_OEN,
  input wire SEL_N,
  input wire SCL_IN,
  output wire SCL_OUT,
  output wire SCL_OEN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OEN,
  output wire PINS_OWNED,
  output wire SLEW_LIMIT_EN,
  output wire SMBUS_LEVELS
);
  localparam [3:0] M_IDLE = 4'b0001;
  localparam [3:0] M_START = 4'b0010;
  localparam [3:0] M_STOP = 4'b0100;
  localparam [3:0] M_BITS = 4'b1000;

  reg sample_phase, edge_select, data_not_addr, halt_seen, begin_flag;
  reg direction_bit, readdress_due, buffer_full;
  reg write_collision, receive_overflow, port_enable, clk_polarity;
  reg [3:0] port_mode_sel;
  reg [7:0] baud_reload_value, shift_buffer;
  reg start_cond_en, restart_cond_en, stop_cond_en, receive_en, ack_seq_en;
  reg ack_data, ack_status;
  reg [7:0] tx_sr, shift_register;
  reg [4:0] edge_idx;
  reg spi_busy, sck_level, sck_q, scl_q, sda_q;
  reg [3:0] i2c_bits;
  reg addr_phase, slv_active, slv_sda_low, slv_hold;
  reg [3:0] mst_state, m_bits, m_nbits;
  reg m_phase, m_rx, m_ackseq, m_addr, m_sda_low, m_scl_low;
  reg [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire is_spi_m = (port_mode_sel[3:2] == 2'h0) || (port_mode_sel == `MODE_SPI_M_BAUD);
  wire is_spi_s = (port_mode_sel == `MODE_SPI_S_SEL) || (port_mode_sel == `MODE_SPI_S_NOSEL);
  wire is_i2c_s = (port_mode_sel[2:1] == 2'h3);
  wire is_i2c_m = (port_mode_sel == `MODE_I2C_MASTER);
  wire is_i2c = is_i2c_s || is_i2c_m || (port_mode_sel == `MODE_I2C_FW_MASTER);
  wire is_spi = is_spi_m || is_spi_s;
  wire ten_bit = is_i2c_s && port_mode_sel[0];
  wire slave_sel = (port_mode_sel == `MODE_SPI_S_NOSEL) || !SEL_N;
  wire mst_idle = !(direction_bit || start_cond_en || restart_cond_en || stop_cond_en ||
    receive_en || ack_seq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources
  wire baud_tick, div_tick;
  wire baud_run = port_enable && ((is_i2c_m && mst_state != M_IDLE) ||
    (spi_busy && port_mode_sel == `MODE_SPI_M_BAUD));
  ssp_baud_gen #(.W(8)) u_baud (
    .clk(CLK),
    .resetn(RESETN),
    .reload_value(baud_reload_value),
    .run(baud_run),
    .tick(baud_tick)
  );
  ssp_spi_div u_div (
    .clk(CLK),
    .resetn(RESETN),
    .rate_sel(port_mode_sel[1:0]),
    .timer_match(TIMER_MATCH),
    .run(port_enable && spi_busy && is_spi_m),
    .tick(div_tick)
  );
  wire spi_tick = (port_mode_sel == `MODE_SPI_M_BAUD) ? baud_tick : div_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Serial peripheral edge bookkeeping
  wire spi_ev = port_enable && (is_spi_m ? (spi_busy && spi_tick) :
    (is_spi_s && slave_sel && SCK_IN != sck_q));
  wire launch = edge_select ? edge_idx[0] : (!edge_idx[0] && edge_idx != 5'h00);
  wire mid = edge_select ? !edge_idx[0] : edge_idx[0];
  wire late = sample_phase && is_spi_m;
  wire take = late ? launch : mid;
  wire last = (late && !edge_select) ? (edge_idx == `SPI_EDGES) : (edge_idx == 5'h0F);
  wire [7:0] spi_byte = take ? {shift_register[6:0], SDI} : shift_register;

  // Two-wire bus events
  wire scl_hi = scl_q && SCL_IN;
  wire start_det = port_enable && is_i2c && scl_hi && sda_q && !SDA_IN;
  wire stop_det = port_enable && is_i2c && scl_hi && !sda_q && SDA_IN;
  wire scl_rise = !scl_q && SCL_IN;
  wire scl_fall = scl_q && !SCL_IN;
  wire addr_hit = shift_register[7:1] == baud_reload_value[7:1];
  wire buf_wr = WR && ADDR == `SSP_IDX_BUF;
  wire xfer_busy = spi_busy || edge_idx != 5'h00 || mst_state != M_IDLE;
  wire m_last = m_bits == m_nbits - 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  always @* begin
    case (ADDR)
      `SSP_IDX_STATUS: rd_mux = {sample_phase, edge_select, data_not_addr, halt_seen, begin_flag,
        direction_bit, readdress_due, buffer_full};
      `SSP_IDX_CTRL1: rd_mux = {write_collision, receive_overflow, port_enable, clk_polarity,
        port_mode_sel};
      `SSP_IDX_BAUD: rd_mux = baud_reload_value;
      `SSP_IDX_BUF: rd_mux = shift_buffer;
      `SSP_IDX_CTRL2: rd_mux = {1'b0, ack_status, ack_data, ack_seq_en, receive_en, stop_cond_en,
        restart_cond_en, start_cond_en};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= `SSP_RESET_VALUE;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and engines; hardware sets come after software clears so they win
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {sample_phase, edge_select, data_not_addr, halt_seen, begin_flag} <= 5'h00;
      {direction_bit, readdress_due, buffer_full, write_collision, receive_overflow} <= 5'h00;
      {port_enable, clk_polarity} <= 2'h0;
      port_mode_sel <= 4'h0;
      baud_reload_value <= `SSP_RESET_VALUE;
      shift_buffer <= `SSP_RESET_VALUE;
      {start_cond_en, restart_cond_en, stop_cond_en, receive_en, ack_seq_en} <= 5'h00;
      {ack_data, ack_status} <= 2'h0;
      tx_sr <= 8'hFF;
      shift_register <= 8'h00;
      edge_idx <= 5'h00;
      {spi_busy, sck_level, sck_q} <= 3'h0;
      {scl_q, sda_q} <= 2'h3;
      i2c_bits <= 4'h0;
      {addr_phase, slv_active, slv_sda_low, slv_hold} <= 4'h0;
      mst_state <= M_IDLE;
      m_bits <= 4'h0;
      m_nbits <= 4'h0;
      {m_phase, m_rx, m_ackseq, m_addr, m_sda_low, m_scl_low} <= 6'h00;
    end else begin
      sck_q <= SCK_IN;
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
      if (WR) begin
        case (ADDR)
          `SSP_IDX_STATUS: begin
            sample_phase <= WDATA[`ST_SAMPLE];
            edge_select <= WDATA[`ST_EDGE];
          end
          `SSP_IDX_CTRL1: begin
            if (!WDATA[`C1_WRITE_COLLISION]) write_collision <= 1'b0;
            if (!WDATA[`C1_OVF]) receive_overflow <= 1'b0;
            port_enable <= WDATA[`C1_EN];
            clk_polarity <= WDATA[`C1_CKP];
            port_mode_sel <= WDATA[3:0];
          end
          `SSP_IDX_BAUD: baud_reload_value <= WDATA;
          `SSP_IDX_CTRL2: begin
            ack_data <= WDATA[`C2_ACKDT];
            if (is_i2c_m && mst_idle) begin
              {ack_seq_en, receive_en, stop_cond_en, restart_cond_en, start_cond_en} <= WDATA[4:0];
            end
          end
          default: begin
          end
        endcase
      end
      if (RD && ADDR == `SSP_IDX_BUF && !(is_i2c_m && direction_bit)) buffer_full <= 1'b0;
      if (buf_wr) begin
        if (xfer_busy) begin
          write_collision <= 1'b1;
        end else begin
          tx_sr <= WDATA;
          if (is_spi_m) spi_busy <= 1'b1;
          if (is_i2c_m && mst_idle) begin
            buffer_full <= 1'b1;
            direction_bit <= 1'b1;
            mst_state <= M_BITS;
            {m_bits, m_phase, m_rx, m_ackseq} <= 7'h00;
            m_nbits <= 4'h9;
            m_sda_low <= !WDATA[7];
          end
        end
      end
      // Serial peripheral shifting, master and slave alike
      if (is_spi_s && !slave_sel) edge_idx <= 5'h00;
      if (spi_ev) begin
        if (is_spi_m && edge_idx < `SPI_EDGES) sck_level <= !sck_level;
        if (launch) tx_sr <= {tx_sr[6:0], 1'b1};
        if (take) shift_register <= {shift_register[6:0], SDI};
        edge_idx <= edge_idx + 5'h01;
        if (last) begin
          edge_idx <= 5'h00;
          spi_busy <= 1'b0;
          if (is_spi_s && buffer_full) begin
            receive_overflow <= 1'b1;
          end else begin
            shift_buffer <= spi_byte;
            buffer_full <= 1'b1;
          end
        end
      end
      // Two-wire conditions seen on the bus
      if (start_det) begin
        begin_flag <= 1'b1;
        halt_seen <= 1'b0;
      end
      if (stop_det) begin
        halt_seen <= 1'b1;
        begin_flag <= 1'b0;
      end
      // Two-wire slave
      if (port_enable && is_i2c_s) begin
        if (start_det || stop_det) begin
          i2c_bits <= 4'h0;
          addr_phase <= start_det;
          slv_active <= 1'b0;
          direction_bit <= 1'b0;
          slv_sda_low <= 1'b0;
          slv_hold <= 1'b0;
        end else begin
          if (scl_rise) begin
            slv_hold <= 1'b0;
            if (i2c_bits < 4'h8) shift_register <= {shift_register[6:0], SDA_IN};
            if (i2c_bits < 4'h9) i2c_bits <= i2c_bits + 4'h1;
            if (i2c_bits == 4'h8 && direction_bit && SDA_IN) begin
              direction_bit <= 1'b0;
              slv_active <= 1'b0;
            end
          end
          if (scl_fall) begin
            slv_hold <= 1'b1;
            if (i2c_bits == 4'h8) begin
              slv_sda_low <= 1'b0;
              if (addr_phase) begin
                addr_phase <= 1'b0;
                if (addr_hit) begin
                  slv_active <= 1'b1;
                  direction_bit <= shift_register[0];
                  data_not_addr <= 1'b0;
                  readdress_due <= ten_bit;
                  slv_sda_low <= 1'b1;
                  shift_buffer <= shift_register;
                  buffer_full <= 1'b1;
                end
              end else if (slv_active && !direction_bit) begin
                data_not_addr <= 1'b1;
                if (buffer_full) begin
                  receive_overflow <= 1'b1;
                end else begin
                  shift_buffer <= shift_register;
                  buffer_full <= 1'b1;
                  slv_sda_low <= 1'b1;
                end
              end
            end else if (i2c_bits == 4'h9) begin
              i2c_bits <= 4'h0;
              slv_sda_low <= slv_active && direction_bit && !tx_sr[7];
            end else if (i2c_bits != 4'h0 && slv_active && direction_bit) begin
              tx_sr <= {tx_sr[6:0], 1'b1};
              slv_sda_low <= !tx_sr[6];
            end
          end
        end
      end
      // Two-wire master
      if (port_enable && is_i2c_m) begin
        case (mst_state)
          M_IDLE: begin
            m_phase <= 1'b0;
            if (start_cond_en || restart_cond_en) begin
              mst_state <= M_START;
              {m_sda_low, m_scl_low} <= 2'h0;
            end else if (stop_cond_en) begin
              mst_state <= M_STOP;
              m_sda_low <= 1'b1;
            end else if (receive_en || ack_seq_en) begin
              mst_state <= M_BITS;
              m_bits <= 4'h0;
              m_rx <= receive_en;
              m_ackseq <= !receive_en;
              m_nbits <= receive_en ? 4'h8 : 4'h1;
              tx_sr <= {ack_data, 7'h7F};
              m_sda_low <= !receive_en && !ack_data;
            end
          end
          M_START: begin
            if (baud_tick) begin
              m_phase <= !m_phase;
              if (!m_phase) begin
                m_sda_low <= 1'b1;
              end else begin
                m_scl_low <= 1'b1;
                m_addr <= 1'b1;
                {start_cond_en, restart_cond_en} <= 2'h0;
                mst_state <= M_IDLE;
              end
            end
          end
          M_STOP: begin
            if (baud_tick) begin
              m_phase <= !m_phase;
              if (!m_phase) begin
                m_scl_low <= 1'b0;
              end else begin
                m_sda_low <= 1'b0;
                stop_cond_en <= 1'b0;
                mst_state <= M_IDLE;
              end
            end
          end
          M_BITS: begin
            if (baud_tick) begin
              m_phase <= !m_phase;
              if (!m_phase) begin
                m_scl_low <= 1'b0;
              end else begin
                m_scl_low <= 1'b1;
                m_bits <= m_bits + 4'h1;
                tx_sr <= {tx_sr[6:0], 1'b1};
                m_sda_low <= !(m_rx || m_bits >= 4'h7 || tx_sr[6]);
                if (m_rx) shift_register <= {shift_register[6:0], SDA_IN};
                if (!m_rx && !m_ackseq && m_bits == 4'h7) begin
                  buffer_full <= 1'b0;
                  data_not_addr <= !m_addr;
                  m_addr <= 1'b0;
                end
                if (!m_rx && !m_ackseq && m_bits == 4'h8) ack_status <= SDA_IN;
                if (m_last) begin
                  mst_state <= M_IDLE;
                  direction_bit <= 1'b0;
                  {receive_en, ack_seq_en} <= 2'h0;
                  if (m_rx) begin
                    data_not_addr <= 1'b1;
                    if (buffer_full) begin
                      receive_overflow <= 1'b1;
                    end else begin
                      shift_buffer <= {shift_register[6:0], SDA_IN};
                      buffer_full <= 1'b1;
                    end
                  end
                end
              end
            end
          end
          default: mst_state <= M_IDLE;
        endcase
      end
      if (!port_enable) begin
        {halt_seen, begin_flag} <= 2'h0;
        {spi_busy, sck_level} <= 2'h0;
        edge_idx <= 5'h00;
        mst_state <= M_IDLE;
        {m_sda_low, m_scl_low, slv_sda_low, slv_hold, slv_active} <= 5'h00;
        {start_cond_en, restart_cond_en, stop_cond_en, receive_en, ack_seq_en} <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; enables are low while the port drives
  wire slv_stretch = is_i2c_s && slv_active && slv_hold && !clk_polarity;
  assign PINS_OWNED = port_enable && (is_spi || is_i2c);
  assign SCK_OUT = sck_level ^ clk_polarity;
  assign SCK_OEN = !(port_enable && is_spi_m);
  assign SDO = tx_sr[7];
  assign SDO_OEN = !(port_enable && (is_spi_m || (is_spi_s && slave_sel)));
  assign SCL_OUT = 1'b0;
  assign SCL_OEN = !(port_enable && ((is_i2c_m && m_scl_low) || slv_stretch));
  assign SDA_OUT = 1'b0;
  assign SDA_OEN = !(port_enable && ((is_i2c_m && m_sda_low) || (is_i2c_s && slv_sda_low)));
  assign SLEW_LIMIT_EN = port_enable && is_i2c && !sample_phase;
  assign SMBUS_LEVELS = port_enable && is_i2c && edge_select;
endmodule
`default_nettype wire

// *** core/ssp_regs.vh ***
// Register indices, field positions, mode codes and reset values of the synchronous serial port
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

`define SSP_IDX_STATUS 3'h0
`define SSP_IDX_CTRL1 3'h1
`define SSP_IDX_BAUD 3'h2
`define SSP_IDX_BUF 3'h3
`define SSP_IDX_CTRL2 3'h4
`define SSP_RESET_VALUE 8'h00

`define ST_SAMPLE 7
`define ST_EDGE 6
`define C1_WRITE_COLLISION 7
`define C1_OVF 6
`define C1_EN 5
`define C1_CKP 4
`define C2_ACKDT 5

`define MODE_SPI_M_FOSC4 4'h0
`define MODE_SPI_S_SEL 4'h4
`define MODE_SPI_S_NOSEL 4'h5
`define MODE_I2C_MASTER 4'h8
`define MODE_SPI_M_BAUD 4'hA
`define MODE_I2C_FW_MASTER 4'hB
`define SPI_EDGES 5'h10
`endif

// *** core/ssp_baud_gen.v ***
// Reload counter that ticks once per baud rollover
`timescale 1ns/1ps
`default_nettype none
module ssp_baud_gen #(
  parameter W = 8
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] reload_value,
  input wire run,
  output wire tick
);
  // One rollover lasts 2*(reload+1) cycles, so two of them make one bus clock period
  reg [W:0] count;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= {(W+1){1'b0}};
    end else if (!run || count == {(W+1){1'b0}}) begin
      count <= {reload_value, 1'b1};
    end else begin
      count <= count - {{W{1'b0}}, 1'b1};
    end
  end

  assign tick = run && (count == {(W+1){1'b0}});
endmodule
`default_nettype wire

// *** core/ssp_spi_div.v ***
// Half-period tick source for the fixed serial peripheral master clock rates
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_div (
  input wire clk,
  input wire resetn,
  input wire [1:0] rate_sel,
  input wire timer_match,
  input wire run,
  output reg tick
);
  reg [4:0] count;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 5'h00;
    end else if (run) begin
      count <= count + 5'h01;
    end else begin
      count <= 5'h00;
    end
  end

  // Half periods of 2, 8 and 32 cycles give CLK/4, CLK/16 and CLK/64
  always @* begin
    case (rate_sel)
      2'h0: tick = run && count[0];
      2'h1: tick = run && (&count[2:0]);
      2'h2: tick = run && (&count);
      default: tick = run && timer_match;
    endcase
  end
endmodule
`default_nettype wire

// *** tb/ssp_chk.sv ***
// Checker for the serial port register and pin rules
`timescale 1ns/1ps
`default_nettype none
module ssp_chk (
  input wire CLK,
  input wire RESETN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire SCK_OUT,
  input wire SCK_OEN,
  input wire SDO_OEN,
  input wire SCL_OEN,
  input wire SDA_OEN,
  input wire PINS_OWNED,
  input wire SLEW_LIMIT_EN,
  input wire SMBUS_LEVELS
);
  reg [5:0] c1;
  reg [1:0] st;
  wire [3:0] m = c1[3:0];
  wire i2c = m inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF};
  wire spim = m inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
  // Shadow of the software-written fields
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      c1 <= 6'h00;
      st <= 2'h0;
    end else if (WR) begin
      if (ADDR == 3'h1) c1 <= WDATA[5:0];
      if (ADDR == 3'h0) st <= WDATA[7:6];
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  a_ctrl_readback: assert property (RD && ADDR == 3'h1 |=> RDATA[5:0] == $past(c1))
    else $error("control one readback wrong");
  a_status_readback: assert property (RD && ADDR == 3'h0 |=> RDATA[7:6] == $past(st))
    else $error("status readback wrong");
  a_pins_owned: assert property (PINS_OWNED == (c1[5] && !(m inside {4'h9, 4'hC, 4'hD})))
    else $error("pin ownership wrong");
  a_pins_released: assert property (!PINS_OWNED |-> SCK_OEN && SDO_OEN && SCL_OEN && SDA_OEN)
    else $error("pin driven while not owned");
  a_master_sck: assert property (PINS_OWNED && spim |-> !SCK_OEN)
    else $error("master clock not driven");
  a_slave_sck: assert property (PINS_OWNED && (m == 4'h4 || m == 4'h5) |-> SCK_OEN)
    else $error("slave drives clock");
  a_slew_sel: assert property (PINS_OWNED && i2c |-> SLEW_LIMIT_EN == !st[1])
    else $error("slew control wrong");
  a_smbus_sel: assert property (PINS_OWNED && i2c |-> SMBUS_LEVELS == st[0])
    else $error("input levels wrong");
  a_sck_half: assert property (PINS_OWNED && m == 4'h1 && $changed(SCK_OUT) |=> $stable(SCK_OUT) [*7])
    else $error("clock half period short");
  c_spi_slow: cover property (m == 4'h1 && $changed(SCK_OUT));
  c_i2c_owned: cover property (PINS_OWNED && i2c);
  c_readback: cover property (RD && ADDR == 3'h1);
endmodule
bind sync_serial_port ssp_chk chk (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .SCK_OUT, .SCK_OEN,
  .SDO_OEN, .SCL_OEN, .SDA_OEN, .PINS_OWNED, .SLEW_LIMIT_EN, .SMBUS_LEVELS);
`default_nettype wire

// *** tb/ssp_peer.sv ***
// Far-side serial peripheral device and two-wire pull-ups
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
  input wire CLK,
  input wire en,
  input wire cke,
  input wire [7:0] tx,
  input wire sck,
  input wire sdo,
  output logic sdi,
  output logic [7:0] rx,
  input wire scl_oen,
  input wire sda_oen,
  output wire scl,
  output wire sda
);
  logic prev;
  logic [7:0] sh;
  int cnt;
  // Released open-drain lines float to their pull-up
  assign scl = scl_oen;
  assign sda = sda_oen;
  always @(posedge CLK) begin
    prev <= sck;
    if (!en) begin
      cnt <= 0;
      sh <= tx;
      sdi <= tx[7];
    end else if (sck !== prev) begin
      cnt <= cnt + 1;
      if (((cnt % 2) == 0) == cke) begin
        rx <= {rx[6:0], sdo};
      end else if (cnt != 0 && cnt < 15) begin
        sh <= sh << 1;
        sdi <= sh[6];
      end
    end else if (cnt >= 16) begin
      // Hold the last bit past the slowest half period, then show a changing line
      cnt <= cnt + 1;
      if (cnt > 80) sdi <= ~sdi;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"
module testbench;
  logic CLK = 0, RESETN = 0, WR = 0, RD = 0, TIMER_MATCH = 0, p_en = 0, p_cke = 0, psel = 0;
  logic [2:0] ADDR = 0;
  logic [7:0] WDATA = 0, p_tx = 0;
  wire [7:0] RDATA, p_rx;
  wire sck, sck_oen, sdi, sdo, scl_oen, sda_oen, scl, sda, owned, slew, smb;
  int bad_count = 0, checks = 0, tm = 0;
  wire probe = psel ? scl : sck;
  always #20 CLK = ~CLK;
  always @(posedge CLK) begin
    tm <= (tm == 4) ? 0 : tm + 1;
    TIMER_MATCH <= (tm == 4);
  end
  sync_serial_port dut (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TIMER_MATCH, .SCK_IN(1'b0),
    .SCK_OUT(sck), .SCK_OEN(sck_oen), .SDI(sdi), .SDO(sdo), .SDO_OEN(), .SEL_N(1'b1), .SCL_IN(scl),
    .SCL_OUT(), .SCL_OEN(scl_oen), .SDA_IN(sda), .SDA_OUT(), .SDA_OEN(sda_oen), .PINS_OWNED(owned),
    .SLEW_LIMIT_EN(slew), .SMBUS_LEVELS(smb));
  ssp_peer peer (.CLK, .en(p_en), .cke(p_cke), .tx(p_tx), .sck(sck), .sdo(sdo), .sdi(sdi), .rx(p_rx),
    .scl_oen(scl_oen), .sda_oen(sda_oen), .scl(scl), .sda(sda));
  ////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    d = RDATA;
  endtask
  task poll(input logic [2:0] a, input int b, input logic v);
    logic [7:0] d;
    for (int i = 0; i < 3000; i++) begin
      rd(a, d);
      if (d[b] === v) return;
    end
    chk("polled bit", {7'h0, v}, {7'h0, d[b]});
    tally_and_finish;
  endtask
  // Cycles between the next two changes of the probed clock line
  task gap(output int n);
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = probe;
      n = 0;
      while (probe === p && n < 3000) begin
        @(posedge CLK);
        n++;
      end
      if (n >= 3000) begin
        chk("clock edge", 8'h01, 8'h00);
        tally_and_finish;
      end
    end
  endtask
  function automatic int half(input int m, input int b);
    case (m)
      0: return 2;
      1: return 8;
      2: return 32;
      3: return 5;
      default: return 2 * (b + 1);
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, t, e;
    int m, b, h;
    int modes[5];
    modes = '{0, 1, 2, 3, 10};
    void'($urandom(7));
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    for (m = 0; m < 8; m++) begin
      rd(m[2:0], d);
      chk("reset value", 8'h00, d);
    end
    for (m = 0; m < 16; m++) begin
      t = 8'($urandom) & 8'hC0;
      if (m == 4 || m == 5) t[7] = 1'b0;
      wr(`SSP_IDX_STATUS, t);
      wr(`SSP_IDX_CTRL1, 8'h20 | m[7:0]);
      @(negedge CLK);
      chk("pins owned", {7'h0, !(m inside {9, 12, 13})}, {7'h0, owned});
      chk("slew", {7'h0, (m inside {6, 7, 8, 11, 14, 15}) && !t[7]}, {7'h0, slew});
      chk("smbus", {7'h0, (m inside {6, 7, 8, 11, 14, 15}) && t[6]}, {7'h0, smb});
    end
    for (int n = 0; n < 10; n++) begin
      m = modes[n % 5];
      b = 1 + $urandom % 5;
      t = 8'($urandom);
      p_tx <= 8'($urandom);
      p_cke <= t[0];
      wr(`SSP_IDX_BAUD, b[7:0]);
      wr(`SSP_IDX_STATUS, {t[2], t[0], 6'h00});
      wr(`SSP_IDX_CTRL1, {2'b00, 1'b1, t[1], m[3:0]});
      @(negedge CLK);
      chk("sck idle", {7'h0, t[1]}, {7'h0, sck});
      @(posedge CLK);
      p_en <= 1'b1;
      d = 8'($urandom);
      wr(`SSP_IDX_BUF, d);
      gap(h);
      chk("sck half period", 8'(half(m, b)), 8'(h));
      wr(`SSP_IDX_BUF, ~d);
      poll(`SSP_IDX_STATUS, 0, 1'b1);
      rd(`SSP_IDX_BUF, e);
      chk("spi receive", p_tx, e);
      chk("peer receive", d, p_rx);
      rd(`SSP_IDX_CTRL1, e);
      chk("collision flags", 8'h80, e & 8'hC0);
      wr(`SSP_IDX_CTRL1, e & 8'h7F);
      rd(`SSP_IDX_CTRL1, e);
      chk("collision cleared", 8'h00, e & 8'h80);
      chk("sck idle after", {7'h0, t[1]}, {7'h0, sck});
      p_en <= 1'b0;
    end
    b = 3 + $urandom % 6;
    psel <= 1'b1;
    wr(`SSP_IDX_BAUD, b[7:0]);
    wr(`SSP_IDX_CTRL1, 8'h28);
    wr(`SSP_IDX_CTRL2, 8'h01);
    poll(`SSP_IDX_CTRL2, 0, 1'b0);
    rd(`SSP_IDX_STATUS, e);
    chk("start seen", 8'h08, e & 8'h18);
    wr(`SSP_IDX_BUF, 8'($urandom));
    rd(`SSP_IDX_STATUS, e);
    chk("transmit flags", 8'h05, e & 8'h05);
    gap(h);
    chk("bus clock phase", 8'(2 * (b + 1)), 8'(h));
    poll(`SSP_IDX_STATUS, 2, 1'b0);
    rd(`SSP_IDX_STATUS, e);
    chk("buffer empty", 8'h00, e & 8'h21);
    wr(`SSP_IDX_CTRL2, 8'h04);
    poll(`SSP_IDX_CTRL2, 2, 1'b0);
    rd(`SSP_IDX_STATUS, e);
    chk("stop seen", 8'h10, e & 8'h18);
    wr(`SSP_IDX_CTRL1, 8'h08);
    @(negedge CLK);
    chk("port released", 8'h00, {7'h0, owned});
    rd(`SSP_IDX_STATUS, e);
    chk("start stop cleared", 8'h00, e & 8'h18);
    tally_and_finish;
  end
endmodule
`default_nettype wire
